// file: core/dcfc_params.svh
`ifndef DCFC_PARAMS_SVH
`define DCFC_PARAMS_SVH

// ==================================================
// register offsets (byte addresses)
`define DCFC_CTRL_OFS 4'h0
`define DCFC_STAT_OFS 4'h4

// ==================================================
// control fields and reset value
`define DCFC_CTRL_FLUSH_BIT 0
`define DCFC_CTRL_HOLD_BIT 1
`define DCFC_CTRL_RST 2'h0

// ==================================================
// status fields
`define DCFC_STAT_PUSHF_LSB 0
`define DCFC_STAT_POPF_LSB 4
`define DCFC_STAT_AF_BIT 8
`define DCFC_STAT_AE_BIT 9
`define DCFC_STAT_BUSY_BIT 10
`define DCFC_STAT_CNT_LSB 16

// ==================================================
// push-side free-room codes
`define DCFC_PSH_FULL 4'h0
`define DCFC_PSH_EMPTY 4'h1
`define DCFC_PSH_HALF 4'h2
`define DCFC_PSH_QTR 4'h3
`define DCFC_PSH_LOWQ 4'h4
`define DCFC_PSH_R32 4'ha
`define DCFC_PSH_R16 4'hb
`define DCFC_PSH_R8 4'hc
`define DCFC_PSH_R4 4'hd
`define DCFC_PSH_R2 4'he
`define DCFC_PSH_R1 4'hf

// ==================================================
// pop-side occupancy codes
`define DCFC_POP_EMPTY 4'h0
`define DCFC_POP_ONE 4'h1
`define DCFC_POP_GE2 4'h2
`define DCFC_POP_GE4 4'h3
`define DCFC_POP_GE8 4'h4
`define DCFC_POP_GE16 4'h5
`define DCFC_POP_GE32 4'h7
`define DCFC_POP_LOWQ 4'h8
`define DCFC_POP_QTR 4'hd
`define DCFC_POP_HALF 4'he
`define DCFC_POP_FULL 4'hf

`endif

// file: core/dcfc_pkg.sv
package dcfc_pkg;
   // flush sequencer states
   typedef enum {fl_idle, fl_wait1, fl_wait2, fl_done} dcfc_flush_t;
   // which side raised the flush
   typedef enum logic {side_push, side_pop} dcfc_side_t;
endpackage

// file: core/dcfc_ram.sv
`timescale 1ns/10ps
module dcfc_ram #(
   parameter int WIDTH = 18,
   parameter int AW = 9
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];

   // ==================================================
   // storage array, registered read port
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
      if (ce && re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// file: core/dcfc_level.sv
`timescale 1ns/10ps
`include "dcfc_params.svh"
module dcfc_level #(
   parameter int AW = 9
) (
   input wire logic [AW:0] count,
   output logic [3:0] push_code,
   output logic [3:0] pop_code,
   output logic almost_full,
   output logic almost_empty
);
   localparam logic [AW:0] DEPTH_V = {1'b1, {AW{1'b0}}};
   localparam logic [AW:0] HALF_V = DEPTH_V >> 1;
   localparam logic [AW:0] QTR_V = DEPTH_V >> 2;
   logic [AW:0] free;

   // ==================================================
   // level encoders
   always_comb begin
      free = DEPTH_V - count;
      almost_full = (free == (AW+1)'(1));
      almost_empty = (count == (AW+1)'(1));
      if (count == DEPTH_V) begin
         push_code = `DCFC_PSH_FULL;
      end else if (count == '0) begin
         push_code = `DCFC_PSH_EMPTY;
      end else if (free > HALF_V) begin
         push_code = `DCFC_PSH_HALF;
      end else if (free > QTR_V) begin
         push_code = `DCFC_PSH_QTR;
      end else if (free >= (AW+1)'(64)) begin
         push_code = `DCFC_PSH_LOWQ;
      end else if (free >= (AW+1)'(32)) begin
         push_code = `DCFC_PSH_R32;
      end else if (free >= (AW+1)'(16)) begin
         push_code = `DCFC_PSH_R16;
      end else if (free >= (AW+1)'(8)) begin
         push_code = `DCFC_PSH_R8;
      end else if (free >= (AW+1)'(4)) begin
         push_code = `DCFC_PSH_R4;
      end else if (free >= (AW+1)'(2)) begin
         push_code = `DCFC_PSH_R2;
      end else begin
         push_code = `DCFC_PSH_R1;
      end
      if (count == '0) begin
         pop_code = `DCFC_POP_EMPTY;
      end else if (count == DEPTH_V) begin
         pop_code = `DCFC_POP_FULL;
      end else if (count >= HALF_V) begin
         pop_code = `DCFC_POP_HALF;
      end else if (count >= QTR_V) begin
         pop_code = `DCFC_POP_QTR;
      end else if (count >= (AW+1)'(64)) begin
         pop_code = `DCFC_POP_LOWQ;
      end else if (count >= (AW+1)'(32)) begin
         pop_code = `DCFC_POP_GE32;
      end else if (count >= (AW+1)'(16)) begin
         pop_code = `DCFC_POP_GE16;
      end else if (count >= (AW+1)'(8)) begin
         pop_code = `DCFC_POP_GE8;
      end else if (count >= (AW+1)'(4)) begin
         pop_code = `DCFC_POP_GE4;
      end else if (count >= (AW+1)'(2)) begin
         pop_code = `DCFC_POP_GE2;
      end else begin
         pop_code = `DCFC_POP_ONE;
      end
   end
endmodule

// file: core/dcfc_top.sv
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "dcfc_params.svh"
// What this block does
// - push side takes 1-36 bit data; a push request stores one word.
// - depth/width pairs 512x18, 512x36, 1024x18 or 2048x9 are supported.
// - almost-full is high while exactly one free location remains.
// - almost-empty is high while exactly one stored word remains.
// - push code 0000 full, 0001 empty, 0010/0011/0100 room over half/quarter/under.
// - pop code 0000 empty, 0001 one, 0010..0111 for 2,4,8,16,32 or more.
// - swap input 1 exchanges the roles of push and pop side signals.
// - each side has its own flush, carried over to the other side.
// - after a push flush almost-full and push code stay invalid until done.
// - the pop-side flush starts on the same edge as a push flush.
// - push flush: two cycles, almost-empty marks completion, push code next edge.
// - pop flush: two cycles, almost-empty marks completion, pop code next edge.
// - asynchronous flush clears both pointers directly, without a clock.
// - push and pop sides are separate logic groups sharing one WIDTH.
// - asynchronous flush polarity is selectable.
// - pop data leaves through a pipeline register.
module dcfc_top #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 512,
   parameter bit ASYNC_FLUSH_INV = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic dir,
   input wire logic async_flush,
   input wire logic [WIDTH-1:0] a_din,
   input wire logic a_req,
   input wire logic a_flush,
   input wire logic [WIDTH-1:0] b_din,
   input wire logic b_req,
   input wire logic b_flush,
   output logic [WIDTH-1:0] dout,
   output logic almost_full,
   output logic almost_empty,
   output logic [3:0] push_flag,
   output logic [3:0] pop_flag,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import dcfc_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam bit CFG_LEGAL = (WIDTH >= 1) && (((DEPTH == 512) && (WIDTH <= 36)) ||
      ((DEPTH == 1024) && (WIDTH <= 18)) || ((DEPTH == 2048) && (WIDTH <= 9)));

   // ==================================================
   // side selection
   logic push_req;
   logic pop_req;
   logic push_flush;
   logic pop_flush;
   logic [WIDTH-1:0] push_data;
   logic aflush_act;

   assign push_req = dir ? b_req : a_req;
   assign pop_req = dir ? a_req : b_req;
   assign push_flush = dir ? b_flush : a_flush;
   assign pop_flush = dir ? a_flush : b_flush;
   assign push_data = dir ? b_din : a_din;
   assign aflush_act = async_flush ^ ASYNC_FLUSH_INV;

   // ==================================================
   // registers
   logic [1:0] ctrl_reg;
   logic [1:0] ctrl_next;
   logic sw_flush_reg;
   logic sw_flush_next;
   logic wb_ack_reg;
   logic wb_ack_next;
   logic [31:0] wb_dat_reg;
   logic [31:0] wb_dat_next;

   // ==================================================
   // flush sequencer
   dcfc_flush_t st_reg;
   dcfc_flush_t st_next;
   dcfc_side_t org_reg;
   dcfc_side_t org_next;
   logic flush_any;
   logic flush_start;
   logic hold;

   assign hold = ctrl_reg[`DCFC_CTRL_HOLD_BIT];
   assign flush_any = push_flush | pop_flush | sw_flush_reg;
   assign flush_start = (st_reg == fl_idle) && flush_any;

   always_comb begin
      st_next = st_reg;
      org_next = org_reg;
      case (st_reg)
         fl_idle: begin
            if (flush_any) begin
               st_next = fl_wait1;
               org_next = (pop_flush && !push_flush && !sw_flush_reg) ? side_pop : side_push;
            end
         end
         fl_wait1: begin
            st_next = fl_wait2;
         end
         fl_wait2: begin
            st_next = fl_done;
         end
         fl_done: begin
            st_next = fl_idle;
         end
         default: begin
            st_next = fl_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= fl_idle;
         org_reg <= side_push;
      end else if (ce) begin
         st_reg <= st_next;
         org_reg <= org_next;
      end
   end

   // ==================================================
   // pointers and their cross-side copies
   logic [AW:0] wptr_reg;
   logic [AW:0] wptr_next;
   logic [AW:0] rptr_reg;
   logic [AW:0] rptr_next;
   logic [AW:0] wptr_s_reg;
   logic [AW:0] wptr_s_next;
   logic [AW:0] rptr_s_reg;
   logic [AW:0] rptr_s_next;
   logic full;
   logic empty;
   logic push_ok;
   logic pop_ok;

   assign full = (wptr_reg ^ rptr_reg) == {1'b1, {AW{1'b0}}};
   assign empty = (wptr_reg == rptr_reg);
   assign push_ok = push_req && !full && (st_reg == fl_idle) && !flush_any && !hold;
   assign pop_ok = pop_req && !empty && (st_reg == fl_idle) && !flush_any && !hold;

   always_comb begin
      wptr_next = wptr_reg + (AW+1)'(push_ok);
      rptr_next = rptr_reg + (AW+1)'(pop_ok);
      wptr_s_next = wptr_reg;
      rptr_s_next = rptr_reg;
      if (flush_start) begin
         wptr_next = '0;
         rptr_next = '0;
         wptr_s_next = '0;
         rptr_s_next = '0;
      end
   end

   always_ff @(posedge clk or posedge rst or posedge aflush_act) begin
      if (rst || aflush_act) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         wptr_s_reg <= '0;
         rptr_s_reg <= '0;
      end else if (ce) begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         wptr_s_reg <= wptr_s_next;
         rptr_s_reg <= rptr_s_next;
      end
   end

   // ==================================================
   // storage and pop pipeline
   logic [WIDTH-1:0] ram_q;
   logic [WIDTH-1:0] dout_reg;
   logic pop_v_reg;

   dcfc_ram #(.WIDTH(WIDTH), .AW(AW)) u_ram (
      .clk(clk),
      .ce(ce),
      .we(push_ok),
      .waddr(wptr_reg[AW-1:0]),
      .wdata(push_data),
      .re(pop_ok),
      .raddr(rptr_reg[AW-1:0]),
      .rdata(ram_q)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dout_reg <= '0;
         pop_v_reg <= 1'b0;
      end else if (ce) begin
         // ram output is undefined until its first read, so take it only after a pop
         pop_v_reg <= pop_ok;
         if (pop_v_reg) begin
            dout_reg <= ram_q;
         end
      end
   end

   // ==================================================
   // level flags, one set per side
   logic [AW:0] cnt_push;
   logic [AW:0] cnt_pop;
   logic [3:0] lv_push_code;
   logic [3:0] lv_pop_code;
   logic lv_af;
   logic lv_ae;
   logic af_reg;
   logic af_next;
   logic ae_reg;
   logic ae_next;
   logic [3:0] pushf_reg;
   logic [3:0] pushf_next;
   logic [3:0] popf_reg;
   logic [3:0] popf_next;

   assign cnt_push = wptr_reg - rptr_s_reg;
   assign cnt_pop = wptr_s_reg - rptr_reg;

   dcfc_level #(.AW(AW)) u_lv_push (
      .count(cnt_push),
      .push_code(lv_push_code),
      .pop_code(),
      .almost_full(lv_af),
      .almost_empty()
   );

   dcfc_level #(.AW(AW)) u_lv_pop (
      .count(cnt_pop),
      .push_code(),
      .pop_code(lv_pop_code),
      .almost_full(),
      .almost_empty(lv_ae)
   );

   always_comb begin
      af_next = af_reg;
      ae_next = ae_reg;
      pushf_next = pushf_reg;
      popf_next = popf_reg;
      case (st_reg)
         fl_idle: begin
            af_next = lv_af;
            ae_next = lv_ae;
            pushf_next = lv_push_code;
            popf_next = lv_pop_code;
         end
         fl_wait1: begin
            // flags frozen in the first flush cycle
            af_next = af_reg;
         end
         fl_wait2: begin
            ae_next = 1'b1;
            if (org_reg == side_push) begin
               popf_next = lv_pop_code;
            end else begin
               pushf_next = lv_push_code;
            end
         end
         fl_done: begin
            af_next = lv_af;
            if (org_reg == side_push) begin
               pushf_next = lv_push_code;
            end else begin
               popf_next = lv_pop_code;
            end
         end
         default: begin
            af_next = af_reg;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         af_reg <= 1'b0;
         ae_reg <= 1'b0;
         pushf_reg <= `DCFC_PSH_EMPTY;
         popf_reg <= `DCFC_POP_EMPTY;
      end else if (ce) begin
         af_reg <= af_next;
         ae_reg <= ae_next;
         pushf_reg <= pushf_next;
         popf_reg <= popf_next;
      end
   end

   // ==================================================
   // wishbone slave
   logic wb_hit;
   logic wb_wr;
   logic [31:0] stat_word;

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_reg;
   assign wb_wr = wb_hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == `DCFC_CTRL_OFS);

   always_comb begin
      stat_word = '0;
      stat_word[`DCFC_STAT_PUSHF_LSB +: 4] = pushf_reg;
      stat_word[`DCFC_STAT_POPF_LSB +: 4] = popf_reg;
      stat_word[`DCFC_STAT_AF_BIT] = af_reg;
      stat_word[`DCFC_STAT_AE_BIT] = ae_reg;
      stat_word[`DCFC_STAT_BUSY_BIT] = (st_reg != fl_idle);
      stat_word[`DCFC_STAT_CNT_LSB +: AW+1] = cnt_pop;
      ctrl_next = ctrl_reg;
      // pending soft flush is held until the sequencer takes it; a new write is ORed in
      sw_flush_next = sw_flush_reg && (st_reg != fl_idle);
      if (wb_wr) begin
         ctrl_next[`DCFC_CTRL_HOLD_BIT] = wb_dat_i[`DCFC_CTRL_HOLD_BIT];
         sw_flush_next = sw_flush_next | wb_dat_i[`DCFC_CTRL_FLUSH_BIT];
      end
      wb_ack_next = wb_hit;
      wb_dat_next = '0;
      if (wb_hit && !wb_we_i) begin
         if (wb_adr_i == `DCFC_CTRL_OFS) begin
            wb_dat_next = {30'h0, ctrl_reg[`DCFC_CTRL_HOLD_BIT], sw_flush_reg};
         end else if (wb_adr_i == `DCFC_STAT_OFS) begin
            wb_dat_next = stat_word;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `DCFC_CTRL_RST;
         sw_flush_reg <= 1'b0;
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= '0;
      end else if (ce) begin
         ctrl_reg <= ctrl_next;
         sw_flush_reg <= sw_flush_next;
         wb_ack_reg <= wb_ack_next;
         wb_dat_reg <= wb_dat_next;
      end
   end

   assign dout = dout_reg;
   assign almost_full = af_reg;
   assign almost_empty = ae_reg;
   assign push_flag = pushf_reg;
   assign pop_flag = popf_reg;
   assign wb_dat_o = wb_dat_reg;
   assign wb_ack_o = wb_ack_reg;

   // ==================================================
   // assertions
   default clocking dcfc_cb @(posedge clk iff ce);
   endclocking
   default disable iff (rst || aflush_act);

   cfg_legal_a: assert property (CFG_LEGAL) else $error("illegal depth/width pair");
   full_ignore_a: assert property (push_req && full && !flush_start |=> wptr_reg == $past(wptr_reg))
      else $error("push accepted while full");
   empty_ignore_a: assert property (pop_req && empty && !flush_start |=> rptr_reg == $past(rptr_reg))
      else $error("pop accepted while empty");
   af_level_a: assert property ((st_reg == fl_idle) |=> af_reg == ($past(cnt_push) == DEPTH - 1))
      else $error("almost full wrong");
   ae_level_a: assert property ((st_reg == fl_idle) |=> ae_reg == ($past(cnt_pop) == 1))
      else $error("almost empty wrong");
   swap_push_a: assert property (dir && b_req && !a_req && push_ok |=> wptr_reg == $past(wptr_reg) + 1)
      else $error("swapped push not taken");
   flush_clear_a: assert property (flush_start |=> wptr_reg == '0 && rptr_reg == '0)
      else $error("flush did not clear pointers");
   push_flush_seq_a: assert property (flush_start && push_flush |-> ##3 (ae_reg && popf_reg == `DCFC_POP_EMPTY)
      ##1 (pushf_reg == `DCFC_PSH_EMPTY)) else $error("push flush sequence wrong");
   pop_flush_seq_a: assert property (flush_start && pop_flush && !push_flush && !sw_flush_reg |-> ##3
      (ae_reg && pushf_reg == `DCFC_PSH_EMPTY) ##1 (popf_reg == `DCFC_POP_EMPTY))
      else $error("pop flush sequence wrong");
   flush_hold_a: assert property (st_reg == fl_wait1 |=> $stable(af_reg) && $stable(pushf_reg))
      else $error("push flags moved during flush");

   fill_full_c: cover property (push_ok ##1 full);
   push_flush_c: cover property (flush_start && push_flush);
   pop_flush_c: cover property (flush_start && pop_flush && !push_flush);
   swap_c: cover property (dir && push_ok ##[1:4] pop_ok);
endmodule

// file: tb/dcfc_pop_user.sv
`timescale 1ns/10ps
// ==================================================
// pop-side user logic: issues pops and pop-side flushes
module dcfc_pop_user (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic fl_go,
   output logic pop_req,
   output logic pop_flush,
   output logic got_v
);
   logic [2:0] v_reg;
   logic [2:0] quiet_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pop_req <= 1'b0;
         pop_flush <= 1'b0;
         v_reg <= 3'h0;
         quiet_reg <= 3'h0;
      end else begin
         // no pops while a flush settles, plus a spare cycle
         pop_req <= go && (quiet_reg == 3'h0);
         pop_flush <= fl_go;
         quiet_reg <= fl_go ? 3'h6 : (quiet_reg != 3'h0 ? quiet_reg - 3'h1 : 3'h0);
         // popped word is read three cycles after the taking edge
         v_reg <= {v_reg[1:0], pop_req};
      end
   end
   assign got_v = v_reg[2];
endmodule

// file: tb/dcfc_top_test.sv
`timescale 1ns/10ps
`include "dcfc_params.svh"
module dcfc_top_test;
   localparam int W = 18;
   localparam int D = 512;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic dir = 1'b0;
   logic async_flush = 1'b0;
   logic push_req = 1'b0;
   logic push_fl = 1'b0;
   logic [W-1:0] push_din = '0;
   logic go = 1'b0;
   logic fl_go = 1'b0;
   logic pop_req, pop_flush, got_v;
   logic [W-1:0] dout, exp_d;
   logic almost_full, almost_empty, wb_ack_o;
   logic [3:0] push_flag, pop_flag;
   logic [3:0] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_we_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic [W-1:0] exp_q[$];
   int err_total = 0;
   int n_compared = 0;
   int cyc_cnt = 0;
   int k = 0;
   dcfc_top #(.WIDTH(W), .DEPTH(D), .ASYNC_FLUSH_INV(1'b0)) i_dut (.clk(clk), .rst(rst), .ce(1'b1), .dir(dir),
      .async_flush(async_flush), .a_din(dir ? ~push_din : push_din), .a_req(dir ? pop_req : push_req),
      .a_flush(dir ? pop_flush : push_fl), .b_din(dir ? push_din : ~push_din), .b_req(dir ? push_req : pop_req),
      .b_flush(dir ? push_fl : pop_flush), .dout(dout), .almost_full(almost_full), .almost_empty(almost_empty),
      .push_flag(push_flag), .pop_flag(pop_flag), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hf),
      .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   dcfc_pop_user i_user (.clk(clk), .rst(rst), .go(go), .fl_go(fl_go), .pop_req(pop_req), .pop_flush(pop_flush),
      .got_v(got_v));
   // ==================================================
   // checking and closing
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic logic [3:0] exp_push(input int c);
      int f = D - c;
      if (c == D) return `DCFC_PSH_FULL;
      if (c == 0) return `DCFC_PSH_EMPTY;
      if (f == 1) return `DCFC_PSH_R1;
      if (f < 4) return `DCFC_PSH_R2;
      if (f < 8) return `DCFC_PSH_R4;
      if (f < 16) return `DCFC_PSH_R8;
      if (f < 32) return `DCFC_PSH_R16;
      if (f < 64) return `DCFC_PSH_R32;
      if (f > D / 2) return `DCFC_PSH_HALF;
      if (f > D / 4) return `DCFC_PSH_QTR;
      return `DCFC_PSH_LOWQ;
   endfunction
   function automatic logic [3:0] exp_pop(input int c);
      if (c == 0) return `DCFC_POP_EMPTY;
      if (c == 1) return `DCFC_POP_ONE;
      if (c == D) return `DCFC_POP_FULL;
      if (c >= D / 2) return `DCFC_POP_HALF;
      if (c >= D / 4) return `DCFC_POP_QTR;
      if (c >= 64) return `DCFC_POP_LOWQ;
      if (c >= 32) return `DCFC_POP_GE32;
      if (c >= 16) return `DCFC_POP_GE16;
      if (c >= 8) return `DCFC_POP_GE8;
      if (c >= 4) return `DCFC_POP_GE4;
      return `DCFC_POP_GE2;
   endfunction
   // ==================================================
   // drivers
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic after(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // push word or push-side flush; returns just after the taking edge
   task automatic push(input bit fl, input logic [W-1:0] d);
      @(posedge clk);
      push_fl <= fl;
      push_req <= !fl;
      push_din <= d;
      @(posedge clk);
      push_fl <= 1'b0;
      push_req <= 1'b0;
      if (!fl) exp_q.push_back(d);
   endtask
   task automatic part(input bit fl);
      @(posedge clk);
      fl_go <= fl;
      go <= !fl;
      @(posedge clk);
      go <= 1'b0;
      fl_go <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fill(input int n);
      for (int i = 0; i < n; i++) push(1'b0, W'(i * 5 + 1));
   endtask
   task automatic flags(input int c);
      check("push_flag", 32'(push_flag), 32'(exp_push(c)));
      check("pop_flag", 32'(pop_flag), 32'(exp_pop(c)));
      check("almost_full", 32'(almost_full), 32'(c == D - 1));
      check("almost_empty", 32'(almost_empty), 32'(c == 1));
   endtask
   always @(posedge clk) begin
      if (got_v === 1'b1) begin
         // a refused pop brings no new word, so the last one must still stand
         if (exp_q.size() > 0) begin
            exp_d = exp_q.pop_front();
         end
         check("dout", 32'(dout), 32'(exp_d));
      end
   end
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      forever #4 clk = ~clk;
   end
   // ==================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      after(1);
      flags(0);
      check("dout", 32'(dout), 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      check("unmapped", rd, 32'h0);
      wb(1'b1, 4'hc, 32'hffffffff);
      wb(1'b0, `DCFC_CTRL_OFS, 32'h0);
      check("ctrl", rd, 32'h0);
      for (k = 1; k <= D + 1; k++) begin
         push(1'b0, W'(k * 7 + 3));
         after(3);
         flags(k > D ? D : k);
      end
      void'(exp_q.pop_back());
      wb(1'b0, `DCFC_STAT_OFS, 32'h0);
      check("count", {22'h0, rd[25:16]}, 32'd512);
      for (k = D - 1; k >= 0; k--) begin
         part(1'b0);
         after(3);
         flags(k);
      end
      part(1'b0);
      after(3);
      flags(0);
      fill(10);
      push(1'b1, '0);
      exp_q.delete();
      after(3);
      check("ae_done", 32'(almost_empty), 32'h1);
      check("pop_flag", 32'(pop_flag), 32'(`DCFC_POP_EMPTY));
      after(1);
      check("push_flag", 32'(push_flag), 32'(`DCFC_PSH_EMPTY));
      after(1);
      check("almost_empty", 32'(almost_empty), 32'h0);
      fill(10);
      part(1'b1);
      exp_q.delete();
      after(3);
      check("ae_done", 32'(almost_empty), 32'h1);
      check("push_flag", 32'(push_flag), 32'(`DCFC_PSH_EMPTY));
      after(1);
      check("pop_flag", 32'(pop_flag), 32'(`DCFC_POP_EMPTY));
      fill(3);
      wb(1'b1, `DCFC_CTRL_OFS, 32'h1);
      exp_q.delete();
      after(8);
      flags(0);
      wb(1'b0, `DCFC_CTRL_OFS, 32'h0);
      check("ctrl", rd, 32'h0);
      wb(1'b1, `DCFC_CTRL_OFS, 32'h2);
      push(1'b0, W'(9));
      void'(exp_q.pop_back());
      after(3);
      flags(0);
      wb(1'b0, `DCFC_CTRL_OFS, 32'h0);
      check("ctrl", rd, 32'h2);
      wb(1'b1, `DCFC_CTRL_OFS, 32'h0);
      fill(5);
      @(posedge clk);
      async_flush <= 1'b1;
      @(posedge clk);
      async_flush <= 1'b0;
      exp_q.delete();
      after(3);
      flags(0);
      wb(1'b0, `DCFC_STAT_OFS, 32'h0);
      check("count", {22'h0, rd[25:16]}, 32'h0);
      dir <= 1'b1;
      fill(2);
      after(3);
      flags(2);
      part(1'b0);
      part(1'b0);
      after(4);
      flags(0);
      dir <= 1'b0;
      after(2);
      give_verdict();
   end
endmodule
